// File: tcc_pkg.sv
// constants, types and register map of the timer capture/compare unit
// Functional notes
// R1 - counter steps through prescaler dividing by 1, 2, 4 or 8
// R2 - source field: 00 halt, 01 clock/12, 11 pin, 10 test
// R3 - prescaler counts input rising edges; cleared on field change or clear
// R4 - counter not writable; cleared by reset or enabled clear-pin edge
// R5 - counter bytes read live with no holding latch
// R6 - idle holds counter and prescaler cleared and stopped
// R7 - four capture registers copy counter on selected edge, raise flag
// R8 - edge bit 2n+1 enables falling, bit 2n rising edge capture
// R9 - three compare registers matched against counter, flag on equality
// R10 - match 0 sets bits 0-5, match 1 clears them, match 2 toggles 6-7
// R11 - simultaneous set and clear matches clear bits 0 to 5
// R12 - compare registers cleared by reset
// R13 - software port access does not disturb match actions
// R14 - byte and wide overflow request one shared interrupt, each selectable
// R15 - flags never cleared by hardware; software clears each one
// R16 - control bit 7 wide select, bit 6 byte select, bit 5 clear enable
// R17 - flag register: bit 7 overflow, 6-4 compare, 3-0 capture
// R18 - per-bit enables gate set, clear and toggle actions
// R19 - a match is seen once when the counter steps onto the value
package tcc_pkg;

    // ==================================================
    // register addresses
    localparam logic [7:0] ADDR_CTRL = 8'hEA;
    localparam logic [7:0] ADDR_EDGE = 8'hEB;
    localparam logic [7:0] ADDR_FLAGS = 8'hC8;
    localparam logic [7:0] ADDR_SET_EN = 8'hEE;
    localparam logic [7:0] ADDR_CLR_TGL = 8'hEF;
    localparam logic [7:0] ADDR_CNT_LO = 8'h80;
    localparam logic [7:0] ADDR_CNT_HI = 8'h81;
    localparam logic [7:0] ADDR_CAP_BASE = 8'h82;
    localparam logic [7:0] ADDR_CMP_BASE = 8'h8A;
    localparam logic [7:0] ADDR_PORT = 8'h90;

    // ==================================================
    // field positions
    localparam int CTRL_WIDE_SEL = 7;
    localparam int CTRL_BYTE_SEL = 6;
    localparam int CTRL_EXT_CLR = 5;
    localparam int CTRL_BYTE_FLAG = 4;
    localparam int CTRL_PRE_LSB = 2;
    localparam int CTRL_SRC_LSB = 0;
    localparam int FLAG_WIDE = 7;
    localparam int FLAG_CMP_LSB = 4;
    localparam int FLAG_CAP_LSB = 0;
    localparam int SET_EN_BITS = 6;

    // ==================================================
    // source codes, counts and reset values
    localparam logic [1:0] SRC_HALT = 2'h0;
    localparam logic [1:0] SRC_OSC = 2'h1;
    localparam logic [1:0] SRC_TEST = 2'h2;
    localparam logic [1:0] SRC_PIN = 2'h3;
    localparam logic [3:0] OSC_DIV_LAST = 4'hB;
    localparam int NUM_CAP = 4;
    localparam int NUM_CMP = 3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [2:0] RST_PRE = 3'h0;

    // ==================================================
    // types
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tcc_bus_req_t;

    typedef struct packed {
        logic [2:0] pre;
    } tcc_pre_state_t;

    typedef struct packed {
        logic [15:0] count;
        logic [3:0] div12;
        logic [7:0] ctrl;
        logic [7:0] edgeCtl;
        logic [7:0] flags;
        logic [5:0] setEn;
        logic [7:0] clrTgl;
        logic [7:0] port;
        logic [NUM_CAP-1:0][15:0] cap;
        logic [NUM_CMP-1:0][15:0] cmp;
        logic stepped;
        logic [7:0] rdata;
        logic ovfIrq;
        logic evtIrq;
    } tcc_state_t;

endpackage : tcc_pkg

// File: tcc_sync_edge.sv
// two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ns
module tcc_sync_edge
    import tcc_pkg::*;
#(
    parameter int WIDTH = 6
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
    } tcc_sync_state_t;

    tcc_sync_state_t st;
    tcc_sync_state_t next_st;

    if (WIDTH < 1) begin : gChk
        $error("tcc_sync_edge: WIDTH must be at least 1");
    end

    // ==================================================
    // stages; only s2 looks at s1
    always_comb begin
        next_st.s1 = asyncIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rise = st.s2 & ~st.s3;
    assign fall = ~st.s2 & st.s3;

endmodule : tcc_sync_edge

// File: tcc_prescaler.sv
// divide-by-1/2/4/8 prescaler in front of the free counter
`timescale 1ns/1ns
module tcc_prescaler
    import tcc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic clear,
    input wire logic [1:0] divSel,
    output logic step
);

    tcc_pre_state_t st;
    tcc_pre_state_t next_st;
    logic [2:0] mask;

    // ==================================================
    // divider
    always_comb begin
        mask = 3'((4'h1 << divSel) - 4'h1); // see R1
        next_st = st;
        if (clear) begin
            next_st.pre = RST_PRE; // see R3
        end else if (tick) begin
            next_st.pre = st.pre + 3'h1; // see R3
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st.pre <= RST_PRE;
        end else begin
            st <= next_st;
        end
    end

    // a clear in the same cycle swallows the tick
    assign step = tick && !clear && ((st.pre & mask) == mask); // see R1

endmodule : tcc_prescaler

// File: tcc_timer_capture_compare.sv
// free counter with capture, compare, port actions and register file
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
module tcc_timer_capture_compare
    import tcc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire tcc_bus_req_t busReq,
    output logic [7:0] rdata,
    input wire logic idleMode,
    input wire logic [NUM_CAP-1:0] captureInput,
    input wire logic extClockPin,
    input wire logic counterClearInput,
    output logic [7:0] portOut,
    output logic irqOverflow,
    output logic irqEvent
);

    tcc_state_t st;
    tcc_state_t next_st;

    // ==================================================
    // the edge and flag registers hold every unit in one byte
    if (2 * NUM_CAP > 8 || NUM_CAP + NUM_CMP + 1 > 8) begin : gFit
        $error("tcc_timer_capture_compare: unit counts overflow a byte");
    end

    // ==================================================
    // pin synchronisers and prescaler
    logic [NUM_CAP+1:0] pinRise;
    logic [NUM_CAP+1:0] pinFall;
    logic preTick;
    logic preClear;
    logic preStep;

    tcc_sync_edge #(
        .WIDTH(NUM_CAP + 2)
    ) uSync (
        .ref_clk(ref_clk),
        .srst(srst),
        .asyncIn({counterClearInput, extClockPin, captureInput}),
        .rise(pinRise),
        .fall(pinFall)
    );

    tcc_prescaler uPre (
        .ref_clk(ref_clk),
        .srst(srst),
        .tick(preTick),
        .clear(preClear),
        .divSel(st.ctrl[CTRL_PRE_LSB+:2]),
        .step(preStep)
    );

    // ==================================================
    // helpers
    function automatic logic wrHit(tcc_bus_req_t r, logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction : wrHit

    logic [1:0] src;
    logic osc12;
    logic cntClear;
    logic fieldChange;
    logic [NUM_CMP-1:0] match;
    logic [NUM_CAP-1:0] capHit;
    logic [7:0] rdNext;
    logic [7:0] portBase;

    // ==================================================
    // counter path
    always_comb begin
        src = st.ctrl[CTRL_SRC_LSB+:2];
        osc12 = (st.div12 == OSC_DIV_LAST);
        // see R2: halt and the test code give no ticks
        unique case (src)
            SRC_OSC: preTick = osc12;
            SRC_PIN: preTick = pinRise[NUM_CAP];
            SRC_HALT, SRC_TEST: preTick = 1'b0;
        endcase
        // see R4
        cntClear = idleMode
            || (pinRise[NUM_CAP+1] && st.ctrl[CTRL_EXT_CLR]);
        fieldChange = wrHit(busReq, ADDR_CTRL)
            && (busReq.wdata[3:0] != st.ctrl[3:0]);
        preClear = cntClear || fieldChange; // see R3 see R6
    end

    // ==================================================
    // next state
    always_comb begin
        next_st = st;
        match = '0;
        capHit = '0;
        portBase = st.port;

        // divide-by-12 machine-cycle tick
        if (idleMode || src != SRC_OSC || osc12) begin
            next_st.div12 = 4'h0;
        end else begin
            next_st.div12 = st.div12 + 4'h1;
        end

        // software-written registers
        if (wrHit(busReq, ADDR_CTRL)) begin
            next_st.ctrl = busReq.wdata; // see R16
        end
        if (wrHit(busReq, ADDR_EDGE)) begin
            next_st.edgeCtl = busReq.wdata;
        end
        if (wrHit(busReq, ADDR_FLAGS)) begin
            next_st.flags = busReq.wdata; // see R15
        end
        if (wrHit(busReq, ADDR_SET_EN)) begin
            next_st.setEn = busReq.wdata[SET_EN_BITS-1:0];
        end
        if (wrHit(busReq, ADDR_CLR_TGL)) begin
            next_st.clrTgl = busReq.wdata;
        end
        if (wrHit(busReq, ADDR_PORT)) begin
            portBase = busReq.wdata;
        end
        for (int n = 0; n < NUM_CMP; n++) begin
            if (wrHit(busReq, ADDR_CMP_BASE + 8'(2 * n))) begin
                next_st.cmp[n][7:0] = busReq.wdata;
            end
            if (wrHit(busReq, ADDR_CMP_BASE + 8'(2 * n + 1))) begin
                next_st.cmp[n][15:8] = busReq.wdata;
            end
        end

        // free counter; no write path exists
        if (cntClear) begin
            next_st.count = RST_WORD; // see R4 see R6
        end else if (preStep) begin
            next_st.count = st.count + 16'h0001; // see R1
            if (st.count[7:0] == 8'hFF) begin
                next_st.ctrl[CTRL_BYTE_FLAG] = 1'b1; // see R14 see R15
            end
            if (st.count == 16'hFFFF) begin
                next_st.flags[FLAG_WIDE] = 1'b1; // see R14 see R17
            end
        end
        next_st.stepped = (next_st.count != st.count); // see R19

        // captures; the hardware set wins over a same-cycle clear
        for (int n = 0; n < NUM_CAP; n++) begin
            capHit[n] = (pinRise[n] && st.edgeCtl[2*n])
                || (pinFall[n] && st.edgeCtl[2*n+1]); // see R8
            if (capHit[n]) begin
                next_st.cap[n] = st.count; // see R7
                next_st.flags[FLAG_CAP_LSB+n] = 1'b1; // see R7 see R17
            end
        end

        // compares are looked at only after the counter moved, so a
        // halted counter sitting on the value does not refire
        for (int n = 0; n < NUM_CMP; n++) begin
            match[n] = st.stepped && (st.count == st.cmp[n]); // see R9 see R19
            if (match[n]) begin
                next_st.flags[FLAG_CMP_LSB+n] = 1'b1; // see R9 see R17
            end
        end

        // port actions act on top of any software write
        next_st.port = portBase; // see R13
        for (int i = 0; i < SET_EN_BITS; i++) begin
            if (match[1] && st.clrTgl[i]) begin
                next_st.port[i] = 1'b0; // see R10 see R11 see R18
            end else if (match[0] && st.setEn[i]) begin
                next_st.port[i] = 1'b1; // see R10 see R18
            end
        end
        for (int i = SET_EN_BITS; i < 8; i++) begin
            if (match[2] && st.clrTgl[i]) begin
                next_st.port[i] = ~portBase[i]; // see R10 see R18
            end
        end

        // requests follow the sticky flags
        next_st.ovfIrq = (next_st.flags[FLAG_WIDE]
            && next_st.ctrl[CTRL_WIDE_SEL])
            || (next_st.ctrl[CTRL_BYTE_FLAG]
            && next_st.ctrl[CTRL_BYTE_SEL]); // see R14
        next_st.evtIrq = |next_st.flags[FLAG_WIDE-1:0];

        // read data in the cycle after the strobe only
        next_st.rdata = busReq.rd ? rdNext : RST_BYTE;
    end

    // ==================================================
    // read decode
    always_comb begin
        rdNext = RST_BYTE;
        unique case (busReq.addr)
            ADDR_CTRL: rdNext = st.ctrl;
            ADDR_EDGE: rdNext = st.edgeCtl;
            ADDR_FLAGS: rdNext = st.flags;
            ADDR_SET_EN: rdNext = {st.port[7:6], st.setEn};
            ADDR_CLR_TGL: rdNext = st.clrTgl;
            ADDR_PORT: rdNext = st.port;
            // live bytes: a carry between two reads can tear the pair
            ADDR_CNT_LO: rdNext = st.count[7:0]; // see R5
            ADDR_CNT_HI: rdNext = st.count[15:8]; // see R5
            default: rdNext = RST_BYTE;
        endcase
        for (int n = 0; n < NUM_CAP; n++) begin
            if (busReq.addr == ADDR_CAP_BASE + 8'(2 * n)) begin
                rdNext = st.cap[n][7:0];
            end
            if (busReq.addr == ADDR_CAP_BASE + 8'(2 * n + 1)) begin
                rdNext = st.cap[n][15:8];
            end
        end
        for (int n = 0; n < NUM_CMP; n++) begin
            if (busReq.addr == ADDR_CMP_BASE + 8'(2 * n)) begin
                rdNext = st.cmp[n][7:0];
            end
            if (busReq.addr == ADDR_CMP_BASE + 8'(2 * n + 1)) begin
                rdNext = st.cmp[n][15:8];
            end
        end
    end

    // ==================================================
    // state register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st.count <= RST_WORD; // see R4
            st.div12 <= 4'h0;
            st.ctrl <= RST_BYTE;
            st.edgeCtl <= RST_BYTE;
            st.flags <= RST_BYTE;
            st.setEn <= '0;
            st.clrTgl <= RST_BYTE;
            st.port <= RST_BYTE;
            st.cap <= '0;
            st.cmp <= '0; // see R12
            st.stepped <= 1'b0;
            st.rdata <= RST_BYTE;
            st.ovfIrq <= 1'b0;
            st.evtIrq <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ==================================================
    // outputs
    assign rdata = st.rdata;
    assign portOut = st.port;
    assign irqOverflow = st.ovfIrq;
    assign irqEvent = st.evtIrq;

endmodule : tcc_timer_capture_compare

// File: tcc_pin_model.sv
// far-side pin model: capture, clear and external count clock pins
`timescale 1ns/1ns
module tcc_pin_model (
    input wire logic ref_clk,
    input wire logic pulseReq,
    input wire logic [3:0] capLvl,
    input wire logic clrLvl,
    output logic [3:0] captureInput,
    output logic extClockPin,
    output logic counterClearInput
);
    // ==================================================
    // pulse framing
    logic [3:0] phase = 4'h0;
    assign captureInput = capLvl;
    assign counterClearInput = clrLvl;
    // a 12-cycle frame keeps the pin at the highest allowed rate
    always_ff @(posedge ref_clk) begin
        if (phase != 4'h0) begin
            phase <= (phase == 4'hB) ? 4'h0 : phase + 4'h1;
        end else if (pulseReq) begin
            phase <= 4'h1;
        end
    end
    // pin rests low outside a frame
    assign extClockPin = (phase != 4'h0) && (phase < 4'h7);
endmodule : tcc_pin_model

// File: tcc_assertions.sv
// port-level checker for the timer capture/compare unit
`timescale 1ns/1ns
module tcc_assertions
    import tcc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire tcc_bus_req_t busReq,
    input wire logic [7:0] rdata,
    input wire logic idleMode,
    input wire logic [NUM_CAP-1:0] captureInput,
    input wire logic extClockPin,
    input wire logic counterClearInput,
    input wire logic [7:0] portOut,
    input wire logic irqOverflow,
    input wire logic irqEvent
);
    // ==================================================
    // helper: last written interrupt selects
    logic [1:0] selSeen;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            selSeen <= 2'h0;
        end else if (busReq.wr && busReq.addr == ADDR_CTRL) begin
            selSeen <= busReq.wdata[7:6];
        end
    end
    // a write lands at its own edge, so it is the same-cycle write that
    // may legally drop a request one cycle later
    logic flagWrite;
    logic ctrlWrite;
    assign flagWrite = busReq.wr && (busReq.addr == ADDR_FLAGS);
    assign ctrlWrite = busReq.wr && (busReq.addr == ADDR_CTRL);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // four idle cycles let any clear-to-zero match settle first
    sequence idleSettled;
        idleMode [*4];
    endsequence
    sequence portWrite;
        busReq.wr && busReq.addr == ADDR_PORT;
    endsequence
    sequence counterRead;
        busReq.rd && busReq.addr == ADDR_CNT_LO;
    endsequence
    // ==================================================
    // assertions
    a_reset_outputs: assert property ($fell(srst) |->
        portOut == RST_BYTE && !irqOverflow && !irqEvent)
        else $error("outputs not clear after reset");
    a_read_one_cycle: assert property (!$past(busReq.rd) |->
        rdata == RST_BYTE) else $error("read data outside its cycle");
    a_unmapped_zero: assert property (busReq.rd && busReq.addr == 8'h00
        |=> rdata == RST_BYTE) else $error("unmapped read not zero");
    a_event_sticky: assert property (irqEvent && !flagWrite
        |=> irqEvent) else $error("event flag dropped by hardware");
    a_overflow_sticky: assert property (irqOverflow
        && !flagWrite && !ctrlWrite |=> irqOverflow)
        else $error("overflow request dropped by hardware");
    a_overflow_select: assert property (selSeen == 2'h0
        && $past(selSeen) == 2'h0 |-> !irqOverflow)
        else $error("overflow request without select");
    a_port_write_idle: assert property (idleSettled ##0 portWrite
        |=> portOut == $past(busReq.wdata)) else $error("port write lost");
    a_idle_counter: assert property (idleSettled ##0 counterRead
        |=> rdata == RST_BYTE) else $error("counter runs in idle");
endmodule : tcc_assertions

bind tcc_timer_capture_compare tcc_assertions chk_u (.ref_clk(ref_clk),
    .srst(srst), .busReq(busReq), .rdata(rdata), .idleMode(idleMode),
    .captureInput(captureInput), .extClockPin(extClockPin),
    .counterClearInput(counterClearInput), .portOut(portOut),
    .irqOverflow(irqOverflow), .irqEvent(irqEvent));

// File: tcc_timer_capture_compare_bench.sv
// self-checking bench for the timer capture/compare unit
`timescale 1ns/1ns
module tcc_timer_capture_compare_bench
    import tcc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    tcc_bus_req_t busReq = '0;
    logic idleMode = 1'b0;
    logic pulseReq = 1'b0;
    logic [3:0] capLvl = 4'h0;
    logic clrLvl = 1'b0;
    logic [3:0] captureInput;
    logic extClockPin, counterClearInput, irqOverflow, irqEvent;
    logic [7:0] rdata, portOut;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    tcc_timer_capture_compare dut_u (.ref_clk(ref_clk), .srst(srst),
        .busReq(busReq), .rdata(rdata), .idleMode(idleMode),
        .captureInput(captureInput), .extClockPin(extClockPin),
        .counterClearInput(counterClearInput), .portOut(portOut),
        .irqOverflow(irqOverflow), .irqEvent(irqEvent));
    tcc_pin_model pins_u (.ref_clk(ref_clk), .pulseReq(pulseReq),
        .capLvl(capLvl), .clrLvl(clrLvl), .captureInput(captureInput),
        .extClockPin(extClockPin), .counterClearInput(counterClearInput));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // ==================================================
    // shared tasks
    task automatic summarize();
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        busReq.wr <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        busReq.rd <= 1'b0;
        #1 check(rdata, exp);
    endtask : rdchk
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_cycles
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            pulseReq <= 1'b1;
            @(posedge ref_clk);
            pulseReq <= 1'b0;
            wait_cycles(12);
        end
    endtask : pulses
    task automatic idle_clear();
        @(posedge ref_clk);
        idleMode <= 1'b1;
        wait_cycles(4);
        rdchk(ADDR_CNT_LO, 8'h00);
        wr(ADDR_PORT, portOut);
        @(posedge ref_clk);
        idleMode <= 1'b0;
    endtask : idle_clear
    // ==================================================
    // scenarios
    task automatic test_reset();
        rdchk(ADDR_CTRL, RST_BYTE);
        rdchk(ADDR_FLAGS, RST_BYTE);
        rdchk(ADDR_CMP_BASE + 8'h05, RST_BYTE);
        rdchk(8'h00, RST_BYTE);
        check(portOut, RST_BYTE);
    endtask : test_reset
    task automatic test_compare();
        wr(ADDR_SET_EN, 8'h3F);
        wr(ADDR_CLR_TGL, 8'h7E);
        wr(ADDR_PORT, 8'h3F);
        for (int n = 0; n < NUM_CMP; n++) wr(ADDR_CMP_BASE + 8'(2 * n), 8'h04);
        wr(ADDR_CTRL, {6'h00, SRC_OSC});
        wait_cycles(100);
        wr(ADDR_CTRL, {6'h00, SRC_HALT});
        #1 check(portOut, 8'h41);
        rdchk(ADDR_FLAGS, 8'h70);
        check(irqEvent, 1'b1);
        wait_cycles(20);
        rdchk(ADDR_FLAGS, 8'h70);
        wr(ADDR_FLAGS, 8'h00);
        rdchk(ADDR_FLAGS, 8'h00);
        check(irqEvent, 1'b0);
    endtask : test_compare
    task automatic test_prescale();
        idle_clear();
        wr(ADDR_CTRL, 8'h0D);
        wait_cycles(12 * 8 * 3 + 30);
        rdchk(ADDR_CNT_LO, 8'h03);
        rdchk(ADDR_CNT_HI, 8'h00);
        wr(ADDR_CTRL, {6'h00, SRC_HALT});
    endtask : test_prescale
    task automatic test_capture();
        idle_clear();
        wr(ADDR_EDGE, 8'hC9);
        wr(ADDR_CTRL, {6'h00, SRC_PIN});
        pulses(5);
        capLvl <= 4'hF;
        wait_cycles(10);
        pulses(2);
        capLvl <= 4'h0;
        wait_cycles(10);
        rdchk(ADDR_CAP_BASE, 8'h05);
        rdchk(ADDR_CAP_BASE + 8'h02, 8'h07);
        rdchk(ADDR_CAP_BASE + 8'h04, 8'h00);
        rdchk(ADDR_CAP_BASE + 8'h06, 8'h07);
        // the count passed the compare value 4, so those flags rise too
        rdchk(ADDR_FLAGS, 8'h7B);
        @(posedge ref_clk);
        clrLvl <= 1'b1;
        wait_cycles(10);
        rdchk(ADDR_CNT_LO, 8'h07);
        @(posedge ref_clk);
        clrLvl <= 1'b0;
        wr(ADDR_CTRL, {6'h08, SRC_PIN});
        clrLvl <= 1'b1;
        wait_cycles(10);
        rdchk(ADDR_CNT_LO, 8'h00);
    endtask : test_capture
    task automatic test_overflow();
        idle_clear();
        wr(ADDR_CTRL, 8'h41);
        wait_cycles(12 * 256 + 20);
        #1 check(irqOverflow, 1'b1);
        rdchk(ADDR_CTRL, 8'h51);
        rdchk(ADDR_CNT_HI, 8'h01);
        wr(ADDR_CTRL, 8'h40);
        #1 check(irqOverflow, 1'b0);
    endtask : test_overflow
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        wait_cycles(20);
        srst <= 1'b0;
        test_reset();
        test_compare();
        test_prescale();
        test_capture();
        test_overflow();
        summarize();
    end
endmodule : tcc_timer_capture_compare_bench
